// ==== rlysel_regs.svh ====
// Purpose: register map, field positions, item codes and timing constants of the relay selector
// Assumes: APB with 8-bit byte addresses and 32-bit data
// Notes: delays are held in 10 ms ticks
`ifndef RLYSEL_REGS_SVH
`define RLYSEL_REGS_SVH
// ****************
// register offsets
// ****************
`define RLY_A_ITEM 8'h00
`define RLY_A_ONDLY 8'h04
`define RLY_A_OFFDLY 8'h08
`define RLY_A_TONDLY 8'h0C
`define RLY_A_TOFFDLY 8'h10
`define RLY_A_LOWFREQ 8'h14
`define RLY_A_ONOFF 8'h18
`define RLY_A_STATUS 8'h1C
`define RLY_A_INTST 8'h20
`define RLY_A_INTMSK 8'h24
// ****************
// fields of the item register
// ****************
`define RLY_F_ITEM1 0
`define RLY_F_ITEM2 8
`define RLY_F_MASK 17
`define RLY_F_CTYPE 20
// ****************
// reset values
// ****************
`define RLY_RST_ITEM1 6'h1D
`define RLY_RST_ITEM2 6'h0E
`define RLY_RST_DLY 16'h0000
`define RLY_RST_MASK 3'h0
`define RLY_DLY_MAX 16'h2710
// ****************
// item codes
// ****************
`define RLY_ITEM_RUN 6'h0E
`define RLY_ITEM_LOWF 6'h17
`define RLY_ITEM_TIMER 6'h1C
`define RLY_ITEM_TRIP 6'h1D
`define RLY_ITEM_ONOFF 6'h22
`define RLY_ITEM_BRAKE 6'h23
`define RLY_ITEM_OVRD 6'h26
`define RLY_ITEM_EBUF 6'h28
`define RLY_ITEM_WARN 6'h2A
// ****************
// positions in the synchronised status vector
// ****************
`define RLY_B_RUN 0
`define RLY_B_VOLT 1
`define RLY_B_DCBRK 2
`define RLY_B_TRIPLV 3
`define RLY_B_TRIPOTH 4
`define RLY_B_RSTFAIL 5
`define RLY_B_TIMER 6
`define RLY_B_BRAKE 7
`define RLY_B_OVRD 8
`define RLY_B_EBUF 9
`define RLY_B_WARN 10
// ****************
// timing
// ****************
`define RLY_TICK_MS 10
`define RLY_CLK_KHZ 50000
`define RLY_TICK_W 20
`endif

// ==== rlysel_pkg.sv ====
// Purpose: types of the relay selector
// Assumes: nothing beyond the register header
// Notes: widths of the state fields follow the register layout
package rlysel_pkg;
  typedef enum logic [1:0] {
    RLYSEL_OFF = 2'h1,
    RLYSEL_ON = 2'h2
  } rlysel_dly_state_type;
  typedef logic [5:0] rlysel_item_type;
  typedef struct packed {
    logic [10:0] b1;
    logic [10:0] b2;
    logic [15:0] f1;
    logic [15:0] f2;
    logic [15:0] a1;
    logic [15:0] a2;
    rlysel_item_type item1;
    rlysel_item_type item2;
    logic [2:0] tmask;
    logic [1:0] ctype;
    logic [15:0] on_dly;
    logic [15:0] off_dly;
    logic [15:0] ton_dly;
    logic [15:0] toff_dly;
    logic [15:0] lf_thr;
    logic [15:0] lf_band;
    logic [15:0] oo_on;
    logic [15:0] oo_off;
    logic lf_det;
    logic oo_det;
    logic [19:0] tick_cnt;
    logic tick;
    logic [1:0] p_out;
    logic p_trip;
    logic relay1;
    logic relay2;
    logic [2:0] ist;
    logic [2:0] imsk;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rlysel_state_type;
endpackage

// ==== rlysel_delay.sv ====
// Purpose: on-delay and off-delay filter for one relay
// Assumes: i_tick is a one-cycle pulse every 10 ms
// Notes: the first tick of a delay may be partial, so a delay may end up to one tick early
`timescale 1ns/1ns
module rlysel_delay #(
  parameter int W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_tick,
  input wire logic i_src,
  input wire logic [W-1:0] i_on_dly,
  input wire logic [W-1:0] i_off_dly,
  output logic o_out
);
  import rlysel_pkg::*;
  typedef struct packed {
    rlysel_dly_state_type state;
    logic [W-1:0] cnt;
  } rlysel_dst_type;
  rlysel_dst_type st;
  rlysel_dst_type next_st;

  always_comb begin
    next_st = st;
    case (st.state)
      RLYSEL_OFF: begin
        if (!i_src) begin
          next_st.cnt = '0;
        end else if (st.cnt >= i_on_dly) begin
          next_st.state = RLYSEL_ON;
          next_st.cnt = '0;
        end else if (i_tick) begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      RLYSEL_ON: begin
        if (i_src) begin
          next_st.cnt = '0;
        end else if (st.cnt >= i_off_dly) begin
          next_st.state = RLYSEL_OFF;
          next_st.cnt = '0;
        end else if (i_tick) begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      default: begin
        next_st.state = RLYSEL_OFF;
        next_st.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{state: RLYSEL_OFF, cnt: '0};
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_out = (st.state == RLYSEL_ON);

  a_dly_off_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st.state == RLYSEL_OFF && !i_src) |=> (st.state == RLYSEL_OFF && st.cnt == '0))
    else $error("output left off state without source");
  a_dly_on_reach: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st.state == RLYSEL_OFF && i_src && st.cnt >= i_on_dly) |=> o_out)
    else $error("on delay expired but output stayed off");
endmodule

// ==== rlysel_top.sv ====
// Purpose: maps drive status conditions onto two relay outputs with item select and delays
// Assumes: status inputs are asynchronous levels; one 50 MHz clock
// Notes: registers over APB; interrupt on relay rise and qualified trip
`timescale 1ns/1ns
`include "rlysel_regs.svh"
module rlysel_top #(
  parameter int TICK_CYCLES = `RLY_TICK_MS * `RLY_CLK_KHZ
) (
  input wire logic I_SYS_CLK,
  input wire logic I_ARST_N,
  input wire logic I_CLK_EN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic [15:0] I_OUT_FREQ,
  input wire logic [15:0] I_ANALOG_IN,
  input wire logic I_RUN_CMD,
  input wire logic I_VOLT_OUT,
  input wire logic I_DC_BRAKE,
  input wire logic I_TRIP_LV,
  input wire logic I_TRIP_OTHER,
  input wire logic I_RESTART_FAIL,
  input wire logic I_TIMER_OUT,
  input wire logic I_BRAKE_RELEASE,
  input wire logic I_OVERRIDE,
  input wire logic I_ENERGY_BUF,
  input wire logic I_WARNING,
  output logic O_RELAY1,
  output logic O_RELAY2,
  output logic O_IRQ
);
  import rlysel_pkg::*;

  // ****************
  // reset release
  // ****************
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ****************
  // helpers
  // ****************
  function automatic logic [15:0] clamp_dly(input logic [15:0] v);
    clamp_dly = (v > `RLY_DLY_MAX) ? `RLY_DLY_MAX : v;
  endfunction

  function automatic logic src_of(input rlysel_item_type item, input logic [10:0] b,
                                  input logic lf, input logic oo, input logic trip);
    case (item)
      `RLY_ITEM_RUN: src_of = b[`RLY_B_RUN] & b[`RLY_B_VOLT] & ~b[`RLY_B_DCBRK];
      `RLY_ITEM_LOWF: src_of = lf;
      `RLY_ITEM_TIMER: src_of = b[`RLY_B_TIMER];
      `RLY_ITEM_TRIP: src_of = trip;
      `RLY_ITEM_ONOFF: src_of = oo;
      `RLY_ITEM_BRAKE: src_of = b[`RLY_B_BRAKE];
      `RLY_ITEM_OVRD: src_of = b[`RLY_B_OVRD];
      `RLY_ITEM_EBUF: src_of = b[`RLY_B_EBUF];
      `RLY_ITEM_WARN: src_of = b[`RLY_B_WARN];
      default: src_of = 1'b0;
    endcase
  endfunction

  rlysel_state_type st;
  rlysel_state_type next_st;
  logic trip_q;
  logic src1;
  logic src2;
  logic [15:0] on_sel1;
  logic [15:0] off_sel1;
  logic [15:0] on_sel2;
  logic [15:0] off_sel2;
  logic d_out1;
  logic d_out2;
  logic apb_wr;
  logic [2:0] ev;

  // ****************
  // source selection
  // ****************
  // trip status inputs are levels held until the trip is reset
  assign trip_q = (st.tmask[0] & st.b2[`RLY_B_TRIPLV])
                | (st.tmask[1] & st.b2[`RLY_B_TRIPOTH])
                | (st.tmask[2] & st.b2[`RLY_B_RSTFAIL]);
  assign src1 = src_of(st.item1, st.b2, st.lf_det, st.oo_det, trip_q);
  assign src2 = src_of(st.item2, st.b2, st.lf_det, st.oo_det, trip_q);
  assign on_sel1 = (st.item1 == `RLY_ITEM_TRIP) ? st.ton_dly : st.on_dly;
  assign off_sel1 = (st.item1 == `RLY_ITEM_TRIP) ? st.toff_dly : st.off_dly;
  assign on_sel2 = (st.item2 == `RLY_ITEM_TRIP) ? st.ton_dly : st.on_dly;
  assign off_sel2 = (st.item2 == `RLY_ITEM_TRIP) ? st.toff_dly : st.off_dly;

  rlysel_delay #(.W(16)) u_dly1 (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_n),
    .i_ce(I_CLK_EN),
    .i_tick(st.tick),
    .i_src(src1),
    .i_on_dly(on_sel1),
    .i_off_dly(off_sel1),
    .o_out(d_out1)
  );

  rlysel_delay #(.W(16)) u_dly2 (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_n),
    .i_ce(I_CLK_EN),
    .i_tick(st.tick),
    .i_src(src2),
    .i_on_dly(on_sel2),
    .i_off_dly(off_sel2),
    .o_out(d_out2)
  );

  assign apb_wr = I_PSEL & I_PENABLE & st.pready & I_PWRITE;
  assign ev = {trip_q & ~st.p_trip, d_out2 & ~st.p_out[1], d_out1 & ~st.p_out[0]};

  // ****************
  // next state
  // ****************
  always_comb begin
    next_st = st;
    // pins are asynchronous, so every status, frequency and analog input passes two flops first
    next_st.b1 = {I_WARNING, I_ENERGY_BUF, I_OVERRIDE, I_BRAKE_RELEASE, I_TIMER_OUT, I_RESTART_FAIL,
                  I_TRIP_OTHER, I_TRIP_LV, I_DC_BRAKE, I_VOLT_OUT, I_RUN_CMD};
    next_st.b2 = st.b1;
    next_st.f1 = I_OUT_FREQ;
    next_st.f2 = st.f1;
    next_st.a1 = I_ANALOG_IN;
    next_st.a2 = st.a1;
    // 10 ms time base
    next_st.tick = 1'b0;
    if (st.tick_cnt >= 20'(TICK_CYCLES - 1)) begin
      next_st.tick_cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 1'b1;
    end
    // low frequency detect with band as hysteresis above the threshold
    if (st.f2 < st.lf_thr) begin
      next_st.lf_det = 1'b1;
    end else if ({1'b0, st.f2} >= ({1'b0, st.lf_thr} + {1'b0, st.lf_band})) begin
      next_st.lf_det = 1'b0;
    end
    // on level wins if the two levels overlap
    if (st.a2 >= st.oo_on) begin
      next_st.oo_det = 1'b1;
    end else if (st.a2 <= st.oo_off) begin
      next_st.oo_det = 1'b0;
    end
    // contact type inverts the output for a break contact
    next_st.relay1 = d_out1 ^ st.ctype[0];
    next_st.relay2 = d_out2 ^ st.ctype[1];
    next_st.p_out = {d_out2, d_out1};
    next_st.p_trip = trip_q;
    // register writes, taken on the edge that completes the access
    if (apb_wr) begin
      case (I_PADDR)
        `RLY_A_ITEM: begin
          next_st.item1 = I_PWDATA[`RLY_F_ITEM1 +: 6];
          next_st.item2 = I_PWDATA[`RLY_F_ITEM2 +: 6];
          next_st.tmask = I_PWDATA[`RLY_F_MASK +: 3];
          next_st.ctype = I_PWDATA[`RLY_F_CTYPE +: 2];
        end
        `RLY_A_ONDLY: next_st.on_dly = clamp_dly(I_PWDATA[15:0]);
        `RLY_A_OFFDLY: next_st.off_dly = clamp_dly(I_PWDATA[15:0]);
        `RLY_A_TONDLY: next_st.ton_dly = clamp_dly(I_PWDATA[15:0]);
        `RLY_A_TOFFDLY: next_st.toff_dly = clamp_dly(I_PWDATA[15:0]);
        `RLY_A_LOWFREQ: begin
          next_st.lf_thr = I_PWDATA[15:0];
          next_st.lf_band = I_PWDATA[31:16];
        end
        `RLY_A_ONOFF: begin
          next_st.oo_on = I_PWDATA[15:0];
          next_st.oo_off = I_PWDATA[31:16];
        end
        `RLY_A_INTST: next_st.ist = st.ist & ~I_PWDATA[2:0];
        `RLY_A_INTMSK: next_st.imsk = I_PWDATA[2:0];
        default: next_st.ist = st.ist;
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_st.ist = next_st.ist | ev;
    next_st.irq = |(next_st.ist & next_st.imsk);
    // two-cycle access: ready rises one cycle into the access phase
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.prdata = 32'h0000_0000;
    if (I_PSEL && I_PENABLE && !st.pready) begin
      next_st.pready = 1'b1;
      case (I_PADDR)
        `RLY_A_ITEM: begin
          next_st.prdata[`RLY_F_ITEM1 +: 6] = st.item1;
          next_st.prdata[`RLY_F_ITEM2 +: 6] = st.item2;
          next_st.prdata[`RLY_F_MASK +: 3] = st.tmask;
          next_st.prdata[`RLY_F_CTYPE +: 2] = st.ctype;
        end
        `RLY_A_ONDLY: next_st.prdata[15:0] = st.on_dly;
        `RLY_A_OFFDLY: next_st.prdata[15:0] = st.off_dly;
        `RLY_A_TONDLY: next_st.prdata[15:0] = st.ton_dly;
        `RLY_A_TOFFDLY: next_st.prdata[15:0] = st.toff_dly;
        `RLY_A_LOWFREQ: next_st.prdata = {st.lf_band, st.lf_thr};
        `RLY_A_ONOFF: next_st.prdata = {st.oo_off, st.oo_on};
        `RLY_A_STATUS: next_st.prdata[7:0] = {st.oo_det, st.lf_det, trip_q, src2, src1, d_out2, st.relay2,
                                              st.relay1};
        `RLY_A_INTST: next_st.prdata[2:0] = st.ist;
        `RLY_A_INTMSK: next_st.prdata[2:0] = st.imsk;
        default: next_st.pslverr = 1'b1;
      endcase
    end
  end

  // ****************
  // state register
  // ****************
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.item1 <= `RLY_RST_ITEM1;
      st.item2 <= `RLY_RST_ITEM2;
      st.tmask <= `RLY_RST_MASK;
      st.on_dly <= `RLY_RST_DLY;
      st.off_dly <= `RLY_RST_DLY;
      st.ton_dly <= `RLY_RST_DLY;
      st.toff_dly <= `RLY_RST_DLY;
    end else if (I_CLK_EN) begin
      st <= next_st;
    end
  end

  assign O_PRDATA = st.prdata;
  assign O_PREADY = st.pready;
  assign O_PSLVERR = st.pslverr;
  assign O_RELAY1 = st.relay1;
  assign O_RELAY2 = st.relay2;
  assign O_IRQ = st.irq;

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!rst_n);

  a_low_freq_set: assert property (I_CLK_EN && st.f2 < st.lf_thr |=> st.lf_det)
    else $error("low frequency not flagged");
  a_trip_lv_path: assert property (st.item1 == `RLY_ITEM_TRIP && st.tmask[0] && st.b2[`RLY_B_TRIPLV]
    |-> src1)
    else $error("low voltage trip not routed");
  a_trip_masked: assert property (st.item2 == `RLY_ITEM_TRIP && st.tmask == 3'h0 |-> !src2)
    else $error("masked trip reached relay");
  a_override_src: assert property (st.item1 == `RLY_ITEM_OVRD |-> src1 == st.b2[`RLY_B_OVRD])
    else $error("override item not followed");
  a_trip_dly_sel: assert property (st.item2 == `RLY_ITEM_TRIP |-> on_sel2 == st.ton_dly
    && off_sel2 == st.toff_dly)
    else $error("trip relay uses general delays");
  a_contact_type: assert property (I_CLK_EN |=> O_RELAY1 == ($past(d_out1) ^ $past(st.ctype[0])))
    else $error("relay contact type wrong");
  a_tick_spaced: assert property (I_CLK_EN && st.tick |=> !st.tick)
    else $error("tick pulse too long");
  a_irq_level: assert property (I_CLK_EN |=> O_IRQ == |($past(next_st.ist) & $past(next_st.imsk)))
    else $error("interrupt level wrong");
  a_apb_ready: assert property (I_CLK_EN && I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
    else $error("ready not given");
endmodule

// ==== rlysel_contacts.sv ====
// Purpose: field-side model of the two relay contacts
// Assumes: coil drive is a level from the relay selector
// Notes: normally-open contacts; armature travel is cut to one cycle so the bench stays short
`timescale 1ns/1ns
module rlysel_contacts (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_coil1,
  input wire logic i_coil2,
  output logic o_closed1,
  output logic o_closed2
);
  // ****************
  // contact state
  // ****************
  // an unpowered coil leaves the contact open, so reset reads open
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_closed1 <= 1'b0;
      o_closed2 <= 1'b0;
    end else begin
      o_closed1 <= i_coil1;
      o_closed2 <= i_coil2;
    end
  end
endmodule

// ==== rlysel_top_tb.sv ====
// Purpose: self-checking bench of the relay selector
// Assumes: tick shortened to 10 cycles; contacts follow the coils one cycle late
// Notes: bus results are queued and checked at the rising edge that samples pready high
`timescale 1ns/1ns
`include "rlysel_regs.svh"
module rlysel_top_tb;
  logic clk, arst_n, psel, pen, pwr, pready, pslverr, rly1, rly2, irq, cls1, cls2;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] freq, ana;
  logic [10:0] st;
  logic [33:0] e;
  logic [33:0] q[$];
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed;
  logic [5:0] codes[6] = '{`RLY_ITEM_RUN, `RLY_ITEM_TIMER, `RLY_ITEM_BRAKE, `RLY_ITEM_OVRD,
    `RLY_ITEM_EBUF, `RLY_ITEM_WARN};
  logic [10:0] srcs[6] = '{11'h003, 11'h040, 11'h080, 11'h100, 11'h200, 11'h400};
  rlysel_top #(.TICK_CYCLES(10)) rlysel_top_inst (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_CLK_EN(1'b1),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_OUT_FREQ(freq), .I_ANALOG_IN(ana),
    .I_RUN_CMD(st[0]), .I_VOLT_OUT(st[1]), .I_DC_BRAKE(st[2]), .I_TRIP_LV(st[3]), .I_TRIP_OTHER(st[4]),
    .I_RESTART_FAIL(st[5]), .I_TIMER_OUT(st[6]), .I_BRAKE_RELEASE(st[7]), .I_OVERRIDE(st[8]),
    .I_ENERGY_BUF(st[9]), .I_WARNING(st[10]), .O_RELAY1(rly1), .O_RELAY2(rly2), .O_IRQ(irq));
  rlysel_contacts rlysel_contacts_inst (.i_clk(clk), .i_rst_n(arst_n), .i_coil1(rly1), .i_coil2(rly2),
    .o_closed1(cls1), .o_closed2(cls2));
  // ****************
  // clock, timeout and checking
  // ****************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    n_checks++;
    if (x !== s) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  // the whole run is near 1200 cycles; a hang is stopped at the 6000-cycle budget, five times that
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  // read data and error are taken at the same edge at which the master sees pready
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      e = q.pop_front();
      chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      if (e[33]) chk("prdata", e[31:0], prdata);
    end
  end
  // ****************
  // bus and relay tasks
  // ****************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x,
    input logic er);
    q.push_back({~wr, er, x});
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // pready ends this wait; if it never rises, only the bench timeout does
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    // let an edge pass so a following call never reassigns the strobes in this time step
    @(posedge clk);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rly(input logic x1, input logic x2);
    @(negedge clk);
    chk("contact1", {31'h0, x1}, {31'h0, cls1});
    chk("contact2", {31'h0, x2}, {31'h0, cls2});
    @(posedge clk);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    seed = 53478;
    arst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    freq = 16'h0000;
    ana = 16'h0000;
    st = 11'h000;
    wt(2);
    arst_n <= 1'b1;
    wt(4);
    apb(0, `RLY_A_ITEM, 0, 32'h0000_0E1D, 0);
    apb(0, `RLY_A_TONDLY, 0, 0, 0);
    apb(0, 8'h40, 0, 0, 1);
    apb(1, `RLY_A_ONDLY, 32'h0000_FFFF, 0, 0);
    apb(0, `RLY_A_ONDLY, 0, 32'h0000_2710, 0);
    apb(1, `RLY_A_ONDLY, 0, 0, 0);
    apb(1, `RLY_A_ITEM, 32'h0030_0000, 0, 0);
    apb(0, `RLY_A_ITEM, 0, 32'h0030_0000, 0);
    wt(6);
    rly(1, 1);
    for (int i = 0; i < 6; i++) begin
      apb(1, `RLY_A_ITEM, {18'h0, codes[i], 2'h0, codes[i]}, 0, 0);
      st <= srcs[i];
      wt(8);
      rly(1, 1);
      st <= 11'h000;
      wt(8);
      rly(0, 0);
    end
    apb(1, `RLY_A_ITEM, 32'h0000_0E0E, 0, 0);
    st <= 11'h007;
    wt(8);
    rly(0, 0);
    st <= 11'h001;
    wt(8);
    rly(0, 0);
    st <= 11'h000;
    // trip relay ignores the general on delay and follows the mask
    apb(1, `RLY_A_ONDLY, 32'h0000_0005, 0, 0);
    for (int m = 0; m < 8; m++) begin
      apb(1, `RLY_A_ITEM, {12'h0, m[2:0], 17'h01D1D}, 0, 0);
      for (int k = 0; k < 3; k++) begin
        st <= 11'(1 << (`RLY_B_TRIPLV + k));
        wt(10);
        rly(m[k], m[k]);
        st <= 11'h000;
        wt(10);
        rly(0, 0);
      end
    end
    apb(1, `RLY_A_ITEM, 32'h000E_001D, 0, 0);
    apb(1, `RLY_A_ONDLY, 0, 0, 0);
    apb(1, `RLY_A_TONDLY, 32'h0000_0003, 0, 0);
    apb(1, `RLY_A_TOFFDLY, 32'h0000_0002, 0, 0);
    apb(1, `RLY_A_INTST, 32'h0000_0007, 0, 0);
    apb(1, `RLY_A_INTMSK, 32'h0000_0004, 0, 0);
    st <= 11'h008;
    wt(14);
    rly(0, 0);
    wt(20);
    rly(1, 0);
    chk("irq", 1, {31'h0, irq});
    apb(0, `RLY_A_INTST, 0, 32'h0000_0005, 0);
    apb(1, `RLY_A_INTST, 32'h0000_0007, 0, 0);
    rly(1, 0);
    chk("irq", 0, {31'h0, irq});
    st <= 11'h000;
    wt(5);
    rly(1, 0);
    wt(25);
    rly(0, 0);
    apb(1, `RLY_A_ITEM, 32'h0000_002A, 0, 0);
    apb(1, `RLY_A_ONDLY, 32'h0000_0003, 0, 0);
    apb(1, `RLY_A_OFFDLY, 32'h0000_0003, 0, 0);
    st <= 11'h400;
    wt(12);
    st <= 11'h000;
    wt(40);
    rly(0, 0);
    st <= 11'h400;
    wt(40);
    rly(1, 0);
    st <= 11'h000;
    wt(12);
    st <= 11'h400;
    wt(40);
    rly(1, 0);
    st <= 11'h000;
    wt(40);
    rly(0, 0);
    apb(1, `RLY_A_ONDLY, 0, 0, 0);
    apb(1, `RLY_A_OFFDLY, 0, 0, 0);
    apb(1, `RLY_A_LOWFREQ, 32'h0100_1000, 0, 0);
    apb(1, `RLY_A_ONOFF, 32'h4000_8000, 0, 0);
    apb(1, `RLY_A_ITEM, 32'h0000_2217, 0, 0);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      freq <= i[0] ? {4'h0, r[11:0]} : {1'b1, r[14:0]};
      ana <= i[0] ? {1'b1, r[30:16]} : {2'h0, r[29:16]};
      wt(10);
      rly(i[0], i[0]);
    end
    tally_and_finish;
  end
endmodule
